// File: inc/global_ctrl_consts.svh
`ifndef GLOBAL_CTRL_CONSTS_SVH
`define GLOBAL_CTRL_CONSTS_SVH

// ----------------------------------------
// Register word indices and byte addresses (index * 4)
// ----------------------------------------
`define ANALOG_DIAG_IDX       8'h0c
`define REVISION_IDX          8'h0d
`define SOFT_RESET_IDX        8'h0e
`define PATTERN_CTRL_IDX      8'h0f
`define MASTER_DIAG_IDX       8'h0a
`define ANALOG_DIAG_ADDR      10'h030
`define REVISION_ADDR         10'h034
`define SOFT_RESET_ADDR       10'h038
`define PATTERN_CTRL_ADDR     10'h03c
`define MASTER_DIAG_ADDR      10'h028

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ANALOG_DIAG_MASK      8'h33
`define VERSION_LSB           0
`define CHIP_TYPE_LSB         5
`define VERSION_EXTRA_POS     6
`define SOFT_RESET_POS        0
`define PAIR3_OFF_POS         7
`define PAIR2_OFF_POS         6
`define PAIR1_OFF_POS         5
`define SEVEN_GEN_POS         4
`define SEVEN_DET_POS         3
`define GEN_RX_PATH_POS       2
`define WHOLE_GEN_POS         1
`define WHOLE_DET_POS         0
`define PATTERN_CTRL_RESET    8'h00
`define ANALOG_DIAG_RESET     8'h00
`define SOFT_RESET_RESET      1'b0
`define RESP_OKAY             2'b00
`define RESP_SLVERR           2'b10

`endif

// File: inc/global_ctrl_pkg.sv
package global_ctrl_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_e;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_e;
endpackage : global_ctrl_pkg

// File: hdl/global_ctrl_pattern_position.sv
`timescale 1ns/1ns
`include "global_ctrl_consts.svh"
// Function
// - Revision register returns fixed five-bit version and three-bit chip type.
// - Older revisions leave bit 6 undriven; newer drives one.
// - Any revision register write pulses a simultaneous counter latch.
// - Software reset bit holds device in reset until software clears it.
// - Software reset also places the device in low-power standby.
// - Hardware reset clears the software reset bit.
// - Bits 7,6,5 gate off clocks of link pairs 3,2,1.
// - Seven-bit generation fills only first seven bits of each channel.
// - Seven-bit generation is ignored under whole-frame generation.
// - Seven-bit detection checks only first seven bits of each channel.
// - Seven-bit detection is ignored under whole-frame detection.
// - Path bit one: generator on receive path, checker on transmit.
// - Path bit zero: checker on receive path, generator on transmit.
// - Whole-frame generation overwrites every bit of the frame.
// - Transmit framing/signalling still win; receive pattern overwrites framing.
// - Whole-frame generation overrides per-timeslot generation.
// - Transmit whole-frame generation suppresses idle code and inversion.
// - Whole-frame detection checks every bit of the frame.
// - Whole-frame detection overrides per-timeslot detection.
module global_ctrl_pattern_position #(
  parameter logic [4:0] VERSION_VALUE  = 5'h03, // Arbitrary value
  parameter logic [2:0] CHIP_TYPE      = 3'h5,  // Arbitrary value
  parameter logic       NEWER_REVISION = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        per_slot_gen_tx,
  input  wire logic        per_slot_gen_rx,
  input  wire logic        per_slot_det_tx,
  input  wire logic        per_slot_det_rx,
  input  wire logic        tx_framing_slot,
  input  wire logic        tx_framing_enabled,
  input  wire logic [2:0]  bit_in_channel,
  output      logic        counter_latch,
  output      logic        device_hold_reset,
  output      logic        low_power_standby,
  output      logic [2:0]  link_pair_clock_on,
  output      logic        gen_tx_active,
  output      logic        gen_rx_active,
  output      logic        det_tx_active,
  output      logic        det_rx_active,
  output      logic        tx_idle_invert_allowed,
  output      logic [7:0]  analog_diag_out
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] analog_diag_reserved;
  logic       software_reset_ctrl;
  logic [7:0] pattern_position_and_link_gating;
  logic       bus_holder6;

  global_ctrl_pkg::wr_state_e wr_state;
  global_ctrl_pkg::rd_state_e rd_state;
  logic [9:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;

  function automatic logic mapped(input logic [9:0] a);
    mapped = (a == `ANALOG_DIAG_ADDR) || (a == `REVISION_ADDR) ||
             (a == `SOFT_RESET_ADDR) || (a == `PATTERN_CTRL_ADDR) ||
             (a == `MASTER_DIAG_ADDR);
  endfunction : mapped

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic do_write;
  assign do_write = aw_held && w_held && (wr_state == global_ctrl_pkg::WR_IDLE);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= 10'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      if (do_write) begin
        aw_held <= 1'b0;
      end else if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= {s_axi_awaddr[9:2], 2'b00};
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= 1'b0;
      if (do_write) begin
        w_held <= 1'b0;
      end else if (s_axi_wvalid && !w_held && !s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_state     <= global_ctrl_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      unique case (wr_state)
        global_ctrl_pkg::WR_IDLE: begin
          if (do_write) begin
            wr_state     <= global_ctrl_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        global_ctrl_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= global_ctrl_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  logic wr_lane0;
  assign wr_lane0 = do_write && w_strb[0];

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Reserved bits must be kept zero by software; only the four real bits store
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_diag_reserved <= `ANALOG_DIAG_RESET;
    end else if (wr_lane0 && aw_addr == `ANALOG_DIAG_ADDR) begin
      analog_diag_reserved <= w_data[7:0] & `ANALOG_DIAG_MASK;
    end
  end

  // Hardware reset or a software write of zero clears this bit; no self clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      software_reset_ctrl <= `SOFT_RESET_RESET;
    end else if (wr_lane0 && aw_addr == `SOFT_RESET_ADDR) begin
      software_reset_ctrl <= w_data[`SOFT_RESET_POS];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pattern_position_and_link_gating <= `PATTERN_CTRL_RESET;
    end else if (wr_lane0 && aw_addr == `PATTERN_CTRL_ADDR) begin
      pattern_position_and_link_gating <= w_data[7:0];
    end
  end

  // Any data value triggers the latch, even with no byte lane enabled
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_latch <= 1'b0;
    end else begin
      counter_latch <= do_write && (aw_addr == `REVISION_ADDR);
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (s_axi_araddr[9:2] == `ANALOG_DIAG_IDX) begin
      rd_byte = analog_diag_reserved;
    end else if (s_axi_araddr[9:2] == `REVISION_IDX) begin
      rd_byte = {CHIP_TYPE, VERSION_VALUE};
    end else if (s_axi_araddr[9:2] == `SOFT_RESET_IDX) begin
      rd_byte = {7'h00, software_reset_ctrl};
    end else if (s_axi_araddr[9:2] == `PATTERN_CTRL_IDX) begin
      rd_byte = pattern_position_and_link_gating;
    end else if (s_axi_araddr[9:2] == `MASTER_DIAG_IDX) begin
      // Older part: bit 6 shows what the holder kept from the last access
      rd_byte[`VERSION_EXTRA_POS] = NEWER_REVISION ? 1'b1 : bus_holder6;
    end
  end

  // Bus holder follows bit 6 of every accepted read or write; a read wins when both land in one cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_holder6 <= 1'b0;
    end else if (rd_state == global_ctrl_pkg::RD_IDLE && s_axi_arvalid && s_axi_arready) begin
      bus_holder6 <= rd_byte[`VERSION_EXTRA_POS];
    end else if (do_write) begin
      bus_holder6 <= w_data[`VERSION_EXTRA_POS];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_state      <= global_ctrl_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      unique case (rd_state)
        // Response only after the address handshake, never alongside it
        global_ctrl_pkg::RD_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            rd_state      <= global_ctrl_pkg::RD_DATA;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= mapped({s_axi_araddr[9:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
          end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
          end
        end
        global_ctrl_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_state     <= global_ctrl_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  logic pc_gen_rx;
  logic pc_whole_gen;
  logic pc_whole_det;
  logic pc_seven_gen;
  logic pc_seven_det;
  logic eighth_bit;
  logic gen_slot;
  logic det_slot;
  assign pc_gen_rx    = pattern_position_and_link_gating[`GEN_RX_PATH_POS];
  assign pc_whole_gen = pattern_position_and_link_gating[`WHOLE_GEN_POS];
  assign pc_whole_det = pattern_position_and_link_gating[`WHOLE_DET_POS];
  assign pc_seven_gen = pattern_position_and_link_gating[`SEVEN_GEN_POS];
  assign pc_seven_det = pattern_position_and_link_gating[`SEVEN_DET_POS];
  assign eighth_bit   = (bit_in_channel == 3'h7);

  // Per-slot requests come from the serial controller on the chosen side
  always_comb begin
    gen_slot = pc_gen_rx ? per_slot_gen_rx : per_slot_gen_tx;
    det_slot = pc_gen_rx ? per_slot_det_tx : per_slot_det_rx;
    if (pc_seven_gen && eighth_bit) begin
      gen_slot = 1'b0;
    end
    if (pc_seven_det && eighth_bit) begin
      det_slot = 1'b0;
    end
  end

  logic next_gen;
  logic next_det;
  // Whole-frame modes override slot and seven-bit settings
  assign next_gen = pc_whole_gen | gen_slot;
  assign next_det = pc_whole_det | det_slot;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      device_hold_reset      <= 1'b0;
      low_power_standby      <= 1'b0;
      link_pair_clock_on     <= 3'h7;
      gen_tx_active          <= 1'b0;
      gen_rx_active          <= 1'b0;
      det_tx_active          <= 1'b0;
      det_rx_active          <= 1'b0;
      tx_idle_invert_allowed <= 1'b1;
      analog_diag_out        <= 8'h00;
    end else begin
      device_hold_reset  <= software_reset_ctrl;
      low_power_standby  <= software_reset_ctrl;
      link_pair_clock_on <= ~{pattern_position_and_link_gating[`PAIR3_OFF_POS],
                              pattern_position_and_link_gating[`PAIR2_OFF_POS],
                              pattern_position_and_link_gating[`PAIR1_OFF_POS]};
      // Framing and signalling insertion still win on transmit
      gen_tx_active <= !pc_gen_rx && next_gen &&
                       !(tx_framing_slot && tx_framing_enabled);
      gen_rx_active <= pc_gen_rx && next_gen;
      det_tx_active <= pc_gen_rx && next_det;
      det_rx_active <= !pc_gen_rx && next_det;
      tx_idle_invert_allowed <= !(pc_whole_gen && !pc_gen_rx);
      analog_diag_out <= analog_diag_reserved;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_latch_on_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (do_write && aw_addr == `REVISION_ADDR) |=> counter_latch)
    else $error("counter latch missing");
  a_soft_reset_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 device_hold_reset == $past(software_reset_ctrl))
    else $error("hold reset wrong");
  a_standby_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    device_hold_reset == low_power_standby)
    else $error("standby mismatch");
  a_pair_gating: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 link_pair_clock_on[2] == !$past(pattern_position_and_link_gating[7]))
    else $error("pair3 gating wrong");
  a_whole_gen_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pc_whole_gen && pc_gen_rx) |=> gen_rx_active)
    else $error("whole frame gen lost");
  a_seven_gap: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!pc_whole_gen && pc_seven_gen && eighth_bit) |=> !gen_tx_active && !gen_rx_active)
    else $error("eighth bit generated");
  a_det_side: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 !(det_tx_active && det_rx_active))
    else $error("checker on both paths");
  a_idle_suppress: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pc_whole_gen && !pc_gen_rx) |=> !tx_idle_invert_allowed)
    else $error("idle code not suppressed");
  a_id_fixed: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (rd_state == global_ctrl_pkg::RD_IDLE && s_axi_arvalid && s_axi_arready &&
     s_axi_araddr[9:2] == `REVISION_IDX) |=>
    s_axi_rdata[7:0] == {CHIP_TYPE, VERSION_VALUE})
    else $error("id field wrong");

endmodule : global_ctrl_pattern_position

// File: sim/global_ctrl_pattern_position_bench.sv
`timescale 1ns/1ns
`include "global_ctrl_consts.svh"
module global_ctrl_pattern_position_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [4:0] VER = 5'h03; // Arbitrary value
  localparam logic [2:0] TYP = 3'h5;  // Arbitrary value
  logic        sys_clk;
  logic        reset_n;
  logic [9:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [3:0]  strb            = 4'hf;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [9:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [3:0]  req;
  logic        fs;
  logic        fe;
  logic [2:0]  bic;
  logic        latch;
  logic        hold;
  logic        lps;
  logic [2:0]  clk_on;
  logic [3:0]  act;
  logic        idle_ok;
  logic [7:0]  ana_out;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          n_latch         = 0;
  int          exp_latch       = 0;
  logic [31:0] seed            = 32'd47879;
  logic [7:0]  ana             = 8'h00;
  logic        chk             = 1'b0;
  logic [33:0] q_rd[$];
  logic [1:0]  q_b[$];
  logic [17:0] q_st[$];

  global_ctrl_pattern_position #(
    .VERSION_VALUE(VER), .CHIP_TYPE(TYP), .NEWER_REVISION(1'b1)
  ) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .per_slot_gen_tx(req[3]), .per_slot_gen_rx(req[2]), .per_slot_det_tx(req[1]),
    .per_slot_det_rx(req[0]), .tx_framing_slot(fs), .tx_framing_enabled(fe),
    .bit_in_channel(bic), .counter_latch(latch), .device_hold_reset(hold),
    .low_power_standby(lps), .link_pair_clock_on(clk_on), .gen_tx_active(act[3]),
    .gen_rx_active(act[2]), .det_tx_active(act[1]), .det_rx_active(act[0]),
    .tx_idle_invert_allowed(idle_ok), .analog_diag_out(ana_out));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Expected status word; per-slot framing overlap is never driven
  function automatic logic [17:0] exp_st(input logic [7:0] p, input logic sr,
                                         input logic [8:0] r);
    logic gg, gd, gt, gr, dt, dr;
    gg = p[4] && (r[8:6] == 3'h7);
    gd = p[3] && (r[8:6] == 3'h7);
    gt = !p[2] && (p[1] ? !(r[4] && r[5]) : (r[3] && !gg));
    gr = p[2] && (p[1] || (r[2] && !gg));
    dt = p[2] && (p[0] || (r[1] && !gd));
    dr = !p[2] && (p[0] || (r[0] && !gd));
    return {sr, sr, ~p[7:5], gt, gr, dt, dr, !(!p[2] && p[1]), ana};
  endfunction : exp_st

  task automatic compare(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task automatic finish_test();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Bus master and stimulus
  // ----------------------------------------
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    q_b.push_back(r);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge sys_clk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    q_rd.push_back({r, d});
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic check_st(input logic [17:0] e);
    q_st.push_back(e);
    @(posedge sys_clk);
    chk <= 1'b1;
    @(posedge sys_clk);
    chk <= 1'b0;
  endtask : check_st

  // Framing slot only offered under whole-frame generation
  task automatic drive_in(input logic [7:0] p);
    logic [8:0] r;
    r = 9'(xs());
    r[4] = r[4] & p[1];
    @(posedge sys_clk);
    req <= r[3:0];
    fs <= r[4];
    fe <= r[5];
    bic <= r[8:6];
    repeat (3) @(posedge sys_clk);
    check_st(exp_st(p, 1'b0, r));
  endtask : drive_in

  task automatic check_latch();
    @(posedge sys_clk);
    compare(34'(n_latch), 34'(exp_latch));
  endtask : check_latch

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (latch === 1'b1) n_latch++;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && q_rd.size() > 0)
      compare({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && q_b.size() > 0)
      compare({32'h0, s_axi_bresp}, {32'h0, q_b.pop_front()});
    if (chk === 1'b1 && q_st.size() > 0)
      compare({16'h0, hold, lps, clk_on, act, idle_ok, ana_out}, {16'h0, q_st.pop_front()});
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    reset_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, req, fs, fe, bic} = '0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    check_st(exp_st(8'h00, 1'b0, 9'h000));
    axi_rd(`REVISION_ADDR, {24'h0, TYP, VER}, `RESP_OKAY);
    axi_rd(`MASTER_DIAG_ADDR, 32'h40, `RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      axi_wr(`REVISION_ADDR, xs(), `RESP_OKAY);
      exp_latch++;
      check_latch();
    end
    axi_rd(`REVISION_ADDR, {24'h0, TYP, VER}, `RESP_OKAY);
    d = xs();
    // Real bits kept zero; noise only in the reserved and upper positions
    axi_wr(`ANALOG_DIAG_ADDR, d & 32'hffff_ffcc, `RESP_OKAY);
    axi_rd(`ANALOG_DIAG_ADDR, 32'h0, `RESP_OKAY);
    axi_wr(10'h3f0, d, `RESP_SLVERR);
    axi_rd(10'h3f0, 32'h0, `RESP_SLVERR);
    check_latch();
    axi_wr(`SOFT_RESET_ADDR, 32'hffffffff, `RESP_OKAY);
    axi_rd(`SOFT_RESET_ADDR, 32'h1, `RESP_OKAY);
    repeat (3) @(posedge sys_clk);
    check_st(exp_st(8'h00, 1'b1, 9'h000));
    axi_wr(`PATTERN_CTRL_ADDR, 32'hff, `RESP_OKAY);
    // Hardware reset in mid-run must clear every control bit
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    ana = 8'h00;
    axi_rd(`SOFT_RESET_ADDR, 32'h0, `RESP_OKAY);
    axi_rd(`PATTERN_CTRL_ADDR, 32'h0, `RESP_OKAY);
    check_st(exp_st(8'h00, 1'b0, 9'h000));
    axi_wr(`SOFT_RESET_ADDR, 32'h1, `RESP_OKAY);
    axi_wr(`SOFT_RESET_ADDR, 32'h0, `RESP_OKAY);
    axi_wr(`ANALOG_DIAG_ADDR, 32'h0, `RESP_OKAY);
    check_st(exp_st(8'h00, 1'b0, 9'h000));
    // No byte lane enabled: latch still fires, nothing stores
    strb = 4'h0;
    axi_wr(`REVISION_ADDR, 32'h0, `RESP_OKAY);
    exp_latch++;
    check_latch();
    axi_wr(`PATTERN_CTRL_ADDR, 32'hff, `RESP_OKAY);
    strb = 4'hf;
    axi_rd(`PATTERN_CTRL_ADDR, 32'h0, `RESP_OKAY);
    // Every pattern control value, random noise in the unused upper bits
    for (int i = 0; i < 256; i++) begin
      d = xs();
      axi_wr(`PATTERN_CTRL_ADDR, {d[31:8], 8'(i)}, `RESP_OKAY);
      axi_rd(`PATTERN_CTRL_ADDR, {24'h0, 8'(i)}, `RESP_OKAY);
      drive_in(8'(i));
      drive_in(8'(i));
    end
    repeat (2) @(posedge sys_clk);
    finish_test();
  end
endmodule : global_ctrl_pattern_position_bench
